// [core/dhp_regs.vh]
`ifndef DHP_REGS_VH
`define DHP_REGS_VH

// Strap level that selects each bus style.
`define DHP_STYLE_MUXED 1'b1
`define DHP_STYLE_SEPARATE 1'b0

// Address of the main interrupt status register, cleared by a read.
`define DHP_ADDR_MAIN_IRQ_STATUS 8'h05

// Reset values.
`define DHP_ADDR_RESET 8'h00
`define DHP_BYTE_RESET 8'h00

// Access state codes.
`define DHP_ST_IDLE 2'b00
`define DHP_ST_READ 2'b01
`define DHP_ST_WRITE 2'b10

`endif

// [core/dhp_strobe_edge.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Strobe edge detector
// ----------------------------------------
// Registers a strobe level and reports its rising and falling edges.
module dhp_strobe_edge (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Strobe level, active high inside this module
  input wire i_level,
  // Edge pulses
  output wire o_rise,
  output wire o_fall
);

  reg level_q;

  // Keep the previous level so that edges last one cycle.
  always @(posedge i_clk) begin
    if (i_rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= i_level;
    end
  end

  assign o_rise = i_level & ~level_q;
  assign o_fall = ~i_level & level_q;

endmodule // dhp_strobe_edge

`default_nettype wire

// [core/dhp_host_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "dhp_regs.vh"

module dhp_host_port #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Bus style strap, high for multiplexed style
  input wire i_style_muxed,
  // Common host controls
  input wire i_chip_select_n,
  input wire i_device_reset_n,
  // Multiplexed style pins
  input wire [DATA_W-1:0] i_shared_addr_data_bus,
  output reg [DATA_W-1:0] o_shared_addr_data_bus,
  output wire o_shared_addr_data_bus_oe,
  input wire i_addr_latch,
  input wire i_read_n,
  input wire i_write_n,
  // Separate style pins
  input wire [ADDR_W-1:0] i_separate_addr_bus,
  input wire [DATA_W-1:0] i_separate_data_bus,
  output reg [DATA_W-1:0] o_separate_data_bus,
  output wire o_separate_data_bus_oe,
  input wire i_data_strobe_n,
  input wire i_read_not_write,
  // Interrupt pin, open drain
  output wire o_irq_n,
  output wire o_irq_n_oe,
  // Register side towards the controller core
  output reg [ADDR_W-1:0] o_reg_addr,
  output reg [DATA_W-1:0] o_reg_wdata,
  output reg o_reg_write,
  output reg o_reg_read,
  input wire [DATA_W-1:0] i_reg_rdata,
  // Interrupt causes from the core
  input wire [DATA_W-1:0] i_irq_set,
  input wire [DATA_W-1:0] i_irq_mask,
  output reg [DATA_W-1:0] o_main_irq_status
);

  // ----------------------------------------
  // Style selection and strobe qualification
  // ----------------------------------------
  // Style follows the strap level; the board ties it, so no retiming is needed.
  wire muxed = (i_style_muxed == `DHP_STYLE_MUXED);
  wire separate = (i_style_muxed == `DHP_STYLE_SEPARATE);
  // Either reset source clears the whole port; the device reset pin is taken as already synchronous.
  wire rst_all = i_rst | ~i_device_reset_n;
  wire selected = ~i_chip_select_n;

  // Read and write levels per style, only while chip select is low.
  // Gating by chip select here keeps a deselected port from seeing any strobe at all.
  wire rd_level = selected & ((muxed & ~i_read_n) | (separate & ~i_data_strobe_n & i_read_not_write));
  wire wr_level = selected & ((muxed & ~i_write_n) | (separate & ~i_data_strobe_n & ~i_read_not_write));
  wire ale_level = selected & muxed & i_addr_latch;

  wire rd_rise;
  wire wr_rise;
  wire wr_fall;
  wire rd_fall;

  // One edge detector each for the read and write strobes. A read starts on the rising edge and ends on the falling edge,
  // while a write needs only its falling edge, since it commits on release.
  dhp_strobe_edge u_rd_edge (
    .i_clk(i_clk),
    .i_rst(rst_all),
    .i_level(rd_level),
    .o_rise(rd_rise),
    .o_fall(rd_fall)
  );

  dhp_strobe_edge u_wr_edge (
    .i_clk(i_clk),
    .i_rst(rst_all),
    .i_level(wr_level),
    .o_rise(),
    .o_fall(wr_fall)
  );

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  // The access is aborted if chip select rises while a strobe is still low,
  // so the cut write is dropped, though a write strobe still low when select returns starts a new write that commits on release.
  // A read cut the same way leaves the status register alone, because the host
  // cannot be sure that it saw the value.
  reg [1:0] state;
  reg [ADDR_W-1:0] latched_addr;
  reg [DATA_W-1:0] read_byte;
  reg [DATA_W-1:0] write_byte;
  reg status_clear;

  // The address and data sources follow the style, so the sequencer itself is style-neutral.
  // The strap must not move outside reset, or an access could mix the two sources.
  wire [ADDR_W-1:0] access_addr = muxed ? latched_addr : i_separate_addr_bus;
  wire [DATA_W-1:0] bus_in = muxed ? i_shared_addr_data_bus : i_separate_data_bus;

  always @(posedge i_clk) begin
    if (rst_all) begin
      state <= `DHP_ST_IDLE;
      latched_addr <= `DHP_ADDR_RESET;
      read_byte <= `DHP_BYTE_RESET;
      write_byte <= `DHP_BYTE_RESET;
      o_reg_addr <= `DHP_ADDR_RESET;
      o_reg_wdata <= `DHP_BYTE_RESET;
      o_reg_write <= 1'b0;
      o_reg_read <= 1'b0;
      status_clear <= 1'b0;
    end else begin
      o_reg_write <= 1'b0;
      o_reg_read <= 1'b0;
      status_clear <= 1'b0;
      // Address phase: the shared lines hold the address while the latch strobe is high.
      if (ale_level) begin
        latched_addr <= i_shared_addr_data_bus;
      end
      case (state)
        `DHP_ST_IDLE: begin
          if (rd_rise) begin
            state <= `DHP_ST_READ;
            o_reg_addr <= access_addr;
            o_reg_read <= 1'b1;
          end else if (wr_level) begin
            state <= `DHP_ST_WRITE;
            o_reg_addr <= access_addr;
          end
        end
        `DHP_ST_READ: begin
          // Sample the core answer once it has had a cycle to settle.
          if (o_reg_read) begin
            read_byte <= (o_reg_addr == `DHP_ADDR_MAIN_IRQ_STATUS) ? o_main_irq_status : i_reg_rdata;
          end
          // A read completes only if chip select is still low on the release edge.
          if (rd_fall & selected) begin
            state <= `DHP_ST_IDLE;
            // Clear only after a completed read, so the host sees the value first.
            status_clear <= (o_reg_addr == `DHP_ADDR_MAIN_IRQ_STATUS);
          end else if (~selected) begin
            state <= `DHP_ST_IDLE;
          end
        end
        `DHP_ST_WRITE: begin
          if (wr_level) begin
            write_byte <= bus_in;
          end
          // The byte held on the last strobe cycle is the one that is committed.
          if (wr_fall & selected) begin
            state <= `DHP_ST_IDLE;
            o_reg_wdata <= write_byte;
            o_reg_write <= 1'b1;
          end else if (~selected) begin
            state <= `DHP_ST_IDLE;
          end
        end
        default: begin
          state <= `DHP_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read data drivers
  // ----------------------------------------
  // Data outputs come from flops; enables follow the live read strobe.
  // The registered byte settles two cycles after the read starts, so the host must hold its strobe.
  // The same byte feeds both buses; only the enable of the active style moves.
  always @(posedge i_clk) begin
    if (rst_all) begin
      o_shared_addr_data_bus <= `DHP_BYTE_RESET;
      o_separate_data_bus <= `DHP_BYTE_RESET;
    end else begin
      o_shared_addr_data_bus <= read_byte;
      o_separate_data_bus <= read_byte;
    end
  end

  wire drive_read = rd_level & (state == `DHP_ST_READ);
  assign o_shared_addr_data_bus_oe = drive_read & muxed;
  assign o_separate_data_bus_oe = drive_read & separate;

  // ----------------------------------------
  // Main interrupt status and pin
  // ----------------------------------------
  // Per bit: a new cause wins over the clear-on-read in the same cycle.
  // Masked causes still set their bit, so software can poll them without the pin.
  genvar b;
  generate
    for (b = 0; b < DATA_W; b = b + 1) begin : g_status
      always @(posedge i_clk) begin
        if (rst_all) begin
          o_main_irq_status[b] <= 1'b0;
        end else if (i_irq_set[b]) begin
          o_main_irq_status[b] <= 1'b1;
        end else if (status_clear) begin
          o_main_irq_status[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // Open drain: the output value is always low, only the enable moves.
  // Limitation: the line returns high only through the board pull-up once released.
  assign o_irq_n = 1'b0;
  assign o_irq_n_oe = |(o_main_irq_status & ~i_irq_mask);

endmodule // dhp_host_port

`default_nettype wire

// [test/dhp_host_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dhp_regs.vh"
// ----------------------------------------
// Host port checker
// ----------------------------------------
module dhp_host_port_chk (
  // Clock and resets
  input wire i_clk, input wire i_rst, input wire i_device_reset_n,
  // Host pins
  input wire i_style_muxed, input wire i_chip_select_n, input wire i_read_n, input wire i_data_strobe_n,
  input wire i_read_not_write, input wire o_irq_n, input wire o_irq_n_oe,
  input wire o_shared_addr_data_bus_oe, input wire o_separate_data_bus_oe,
  // Core side
  input wire [7:0] o_reg_addr, input wire o_reg_write, input wire o_reg_read,
  input wire [7:0] i_irq_set, input wire [7:0] i_irq_mask, input wire [7:0] o_main_irq_status
);
  // Either reset forces the outputs low, so the checks rest meanwhile.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst || !i_device_reset_n);
  a_irq_pin_low: assert property (o_irq_n == 1'b0) else $error("irq pin not low");
  a_irq_pull_cause: assert property (o_irq_n_oe == |(o_main_irq_status & ~i_irq_mask))
    else $error("irq enable wrong");
  a_status_set_cause: assert property ((o_main_irq_status & ~$past(o_main_irq_status) & ~$past(i_irq_set)) == 8'h00)
    else $error("status set without cause");
  a_clear_needs_read: assert property ($past(i_device_reset_n) && !$past(i_rst)
    && |($past(o_main_irq_status) & ~o_main_irq_status)
    |-> $past(o_reg_addr, 2) == `DHP_ADDR_MAIN_IRQ_STATUS) else $error("status cleared without read");
  a_cs_blocks_strobes: assert property ($past(i_chip_select_n) && $past(i_chip_select_n, 2)
    |-> !o_reg_write && !o_reg_read) else $error("access without chip select");
  a_write_single: assert property (o_reg_write |=> !o_reg_write) else $error("write pulse long");
  a_mux_oe_read: assert property (o_shared_addr_data_bus_oe |-> i_style_muxed && !i_read_n)
    else $error("shared bus driven outside read");
  a_sep_oe_read: assert property (o_separate_data_bus_oe
    |-> !i_style_muxed && !i_data_strobe_n && i_read_not_write) else $error("data bus driven outside read");
  c_write: cover property (o_reg_write);
  c_mux_read: cover property (o_reg_read && i_style_muxed);
  c_sep_read: cover property (o_reg_read && !i_style_muxed);
  c_irq_release: cover property ($fell(o_irq_n_oe));
endmodule // dhp_host_port_chk
bind dhp_host_port dhp_host_port_chk u_chk (.*);
`default_nettype wire

// [test/dhp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host processor model
// ----------------------------------------
module dhp_host_model (
  // Clock, cut control and read data from the port
  input wire i_clk, input wire i_cut, input wire [7:0] i_mux_q, input wire [7:0] i_sep_q,
  // Host pins
  output logic o_cs_n = 1'b1, output logic [7:0] o_ad = 8'h00, output logic o_ale = 1'b0,
  output logic o_rd_n = 1'b1, output logic o_wr_n = 1'b1, output logic [7:0] o_a = 8'h00,
  output logic [7:0] o_d = 8'h00, output logic o_ds_n = 1'b1, output logic o_rnw = 1'b1
);
  // One byte per access; the strobe stays low six cycles, above the read minimum of four.
  task automatic acc(input logic m, input logic rd, input logic csn, input logic [7:0] adr,
                     input logic [7:0] dat, output logic [7:0] q);
    @(posedge i_clk) #1 o_cs_n = csn;
    o_ale = m;
    o_ad = adr;
    o_a = adr;
    o_rnw = rd;
    @(posedge i_clk) #1 o_ale = 1'b0;
    o_ad = rd ? ~dat : dat;
    o_d = o_ad;
    o_rd_n = !(m && rd);
    o_wr_n = !(m && !rd);
    o_ds_n = m;
    repeat (6) @(posedge i_clk);
    q = m ? i_mux_q : i_sep_q;
    #1 {o_rd_n, o_wr_n, o_ds_n} = 3'b111;
    // A cut access lifts chip select together with the strobe.
    if (i_cut) o_cs_n = 1'b1;
    @(posedge i_clk) #1 o_cs_n = 1'b1;
    // A released bus must not keep showing the last byte.
    o_ad = ~o_ad;
    o_d = ~o_d;
  endtask
endmodule // dhp_host_model
`default_nettype wire

// [test/tb_dual_style_host_bus_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dhp_regs.vh"
// ----------------------------------------
// Host port bench
// ----------------------------------------
module tb_dual_style_host_bus_port;
  logic clk = 1'b0, rst = 1'b1, mux = 1'b1, drst_n = 1'b1, cut = 1'b0;
  logic [7:0] irqs = 8'h00, mask = 8'h00, q, wa, wd;
  int errors = 0, compares = 0, nwr = 0, nrd = 0;
  wire cs_n, ale, rd_n, wr_n, ds_n, rnw, aoe, doe, irq_n, irq_oe, rwr, rrd;
  wire [7:0] ad, a, d, aq, dq, radr, rdat, st;
  // The host sees read data only while the port enables its driver, otherwise the inverse.
  dhp_host_model host (.i_clk(clk), .i_cut(cut), .i_mux_q(aoe ? aq : ~aq), .i_sep_q(doe ? dq : ~dq),
    .o_cs_n(cs_n), .o_ad(ad), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_a(a), .o_d(d), .o_ds_n(ds_n),
    .o_rnw(rnw));
  // Each data wire carries whichever party enables its driver.
  dhp_host_port dut (.i_clk(clk), .i_rst(rst), .i_style_muxed(mux), .i_chip_select_n(cs_n),
    .i_device_reset_n(drst_n), .i_shared_addr_data_bus(aoe ? aq : ad), .o_shared_addr_data_bus(aq),
    .o_shared_addr_data_bus_oe(aoe), .i_addr_latch(ale), .i_read_n(rd_n), .i_write_n(wr_n),
    .i_separate_addr_bus(a), .i_separate_data_bus(doe ? dq : d), .o_separate_data_bus(dq),
    .o_separate_data_bus_oe(doe), .i_data_strobe_n(ds_n), .i_read_not_write(rnw), .o_irq_n(irq_n),
    .o_irq_n_oe(irq_oe), .o_reg_addr(radr), .o_reg_wdata(rdat), .o_reg_write(rwr), .o_reg_read(rrd),
    .i_reg_rdata(~radr), .i_irq_set(irqs), .i_irq_mask(mask), .o_main_irq_status(st));
  initial forever #20 clk = ~clk;
  // The core side logs every committed write.
  always @(posedge clk) if (rwr) begin
    nwr <= nwr + 1;
    wa <= radr;
    wd <= rdat;
  end
  always @(posedge clk) if (rrd) nrd <= nrd + 1;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A write commits once, or not at all when chip select is high.
  task automatic wr(input logic m, input logic csn, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = nwr + !csn;
    host.acc(m, 1'b0, csn, adr, dat, q);
    repeat (3) @(posedge clk);
    #1 chk("write count", n[7:0], nwr[7:0]);
    if (!csn) begin
      chk("write addr", adr, wa);
      chk("write data", dat, wd);
    end
  endtask
  // The strap is moved only under device reset, since it is a static level.
  task automatic test_styles();
    int n;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) #1 drst_n = 1'b0;
      mux = m[0];
      @(posedge clk) #1 drst_n = 1'b1;
      wr(m[0], 1'b0, 8'h3c ^ m[7:0], 8'h5a ^ m[7:0]);
      n = nrd;
      host.acc(m[0], 1'b1, 1'b0, 8'h21 ^ m[7:0], 8'h00, q);
      chk("read data", ~(8'h21 ^ m[7:0]), q);
      chk("read count", n[7:0] + 8'h01, nrd[7:0]);
    end
    $display("test styles done");
  endtask
  // Lifting chip select with the strobe cuts the access: no write lands and no status clears.
  task automatic test_refused();
    int n;
    wr(1'b1, 1'b1, 8'h44, 8'h77);
    @(posedge clk) #1 irqs = 8'h08;
    @(posedge clk) #1 irqs = 8'h00;
    cut = 1'b1;
    n = nwr;
    host.acc(1'b1, 1'b0, 1'b0, 8'h45, 8'h12, q);
    host.acc(1'b1, 1'b1, 1'b0, `DHP_ADDR_MAIN_IRQ_STATUS, 8'h00, q);
    cut = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("cut write count", n[7:0], nwr[7:0]);
    chk("cut read status", 8'h08, st);
    host.acc(1'b1, 1'b1, 1'b0, `DHP_ADDR_MAIN_IRQ_STATUS, 8'h00, q);
    chk("status read back", 8'h08, q);
    $display("test refused done");
  endtask
  // A masked cause must not pull the pin, yet still reads back and clears.
  task automatic test_irq();
    @(posedge clk) #1 mask = 8'h02;
    irqs = 8'h02;
    @(posedge clk) #1 irqs = 8'h00;
    repeat (2) @(posedge clk);
    #1 chk("masked pull", 8'h00, {7'h0, irq_oe});
    irqs = 8'h04;
    @(posedge clk) #1 irqs = 8'h00;
    repeat (2) @(posedge clk);
    #1 chk("pull", 8'h01, {7'h0, irq_oe});
    host.acc(1'b1, 1'b1, 1'b0, `DHP_ADDR_MAIN_IRQ_STATUS, 8'h00, q);
    chk("status read", 8'h06, q);
    repeat (3) @(posedge clk);
    #1 chk("status", 8'h00, st);
    chk("release", 8'h00, {7'h0, irq_oe});
    $display("test irq done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    test_styles();
    test_refused();
    test_irq();
    close_out();
  end
endmodule // tb_dual_style_host_bus_port
`default_nettype wire
